/* lcd_ram_load_and_scan.sv */
// Display RAM loader and row scanner with AXI4-Lite registers.
// Assumes one AXI4-Lite master, one write and one read at a time.
`timescale 1ns/1ps
module lcd_ram_load_and_scan import lcd_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_clk_pin,
  input  wire logic [2:0]  hw_subaddress_pins,
  input  wire logic        sync_n_in,
  output logic             sync_n_out,
  output logic             sync_n_oe,
  output logic             display_ack,
  output logic [39:0]      segment_outputs,
  output logic [3:0]       backplane_outputs
);
  typedef struct packed {
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
    logic            aw_got;
    logic            w_got;
    logic [7:0]      awaddr;
    logic [7:0]      wdata;
    logic            wlane0;
    logic [7:0]      ctrl;
    logic [5:0]      ptr;
    logic [2:0]      sub;
    lcd_ld_t         ld;
    logic [7:0]      dbyte;
    logic [2:0]      bcnt;
    logic [1:0]      lrow;
    logic [39:0][3:0] ram;
    logic [39:0]     shreg;
    logic [39:0]     disp;
    logic [5:0]      scol;
    logic [1:0]      cur_row;
    logic            pol;
    logic [39:0]     seg;
    logic [3:0]      bp;
    logic            ack;
  } lcd_core_t;

  lcd_core_t  s_q;
  lcd_core_t  s_d;
  lcd_mux_t   mux;
  logic [2:0] per;
  logic [1:0] wbase;
  logic [1:0] obase;
  logic [1:0] nrow;
  logic       bitv;
  logic       ext_rise;
  logic       tick;
  logic [1:0] row_idx;
  logic       phase_end;
  logic       frame_start;
  logic       busy;

  // Mapped register addresses
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == REG_CTRL) || (a == REG_PTR) || (a == REG_SUB) ||
              (a == REG_DATA) || (a == REG_STAT);
  endfunction

  lcd_edge_det u_ext_edge (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .level_in (ext_clk_pin),
    .rise     (ext_rise)
  );

  assign tick = s_q.ctrl[CTRL_EXT_CLK] ? ext_rise : 1'b1;

  lcd_frame_timer u_timer (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .tick        (tick),
    .power_save  (s_q.ctrl[CTRL_PSAVE]),
    .mux         (mux),
    .sync_n_in   (sync_n_in),
    .sync_n_out  (sync_n_out),
    .sync_n_oe   (sync_n_oe),
    .row_idx     (row_idx),
    .phase_end   (phase_end),
    .frame_start (frame_start)
  );

  assign busy = (s_q.ld == LD_BITS);

  always_comb begin
    mux = lcd_mux_t'(s_q.ctrl[CTRL_MUX_LSB +: 2]);
    per = rows_of(mux);
    // input bank, static and 1:2 only
    wbase = (s_q.ctrl[CTRL_IN_BANK] && mux <= MUX_1_2) ? BANK_ALT_ROW : 2'h0;
    // output bank, independent of input bank
    obase = (s_q.ctrl[CTRL_OUT_BANK] && mux <= MUX_1_2) ? BANK_ALT_ROW : 2'h0;
    nrow = ({1'b0, row_idx} >= per - 3'h1) ? 2'h0 : row_idx + 2'h1;
    bitv = s_q.dbyte[3'h7 - s_q.bcnt];
    s_d = s_q;

    // Write address and data taken in either order
    if (s_q.awready && s_axi_awvalid) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata[7:0];
      s_d.wlane0 = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // writes wait until the byte in flight is stored
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid && !busy) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = addr_ok(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.wlane0) begin
        case (s_q.awaddr)
          REG_CTRL: begin
            s_d.ctrl = s_q.wdata;
          end
          // load pointer, kept inside the RAM
          REG_PTR: begin
            s_d.ptr = (s_q.wdata[5:0] > LAST_COL) ? LAST_COL : s_q.wdata[5:0];
          end
          REG_SUB: begin
            s_d.sub = s_q.wdata[2:0];
          end
          // every byte here is display data
          REG_DATA: begin
            s_d.ld = LD_BITS;
            s_d.dbyte = s_q.wdata;
            s_d.bcnt = 3'h0;
            s_d.lrow = 2'h0;
          end
          default: begin
          end
        endcase
      end
    end
    s_d.awready = !s_d.aw_got;
    s_d.wready = !s_d.w_got;

    // Read channel, one beat in flight
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.arready && s_axi_arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        REG_CTRL: s_d.rdata = {24'h00_0000, s_q.ctrl};
        REG_PTR:  s_d.rdata = {26'h000_0000, s_q.ptr};
        REG_SUB:  s_d.rdata = {29'h0000_0000, s_q.sub};
        REG_STAT: s_d.rdata = {28'h000_0000, s_q.ack, s_q.cur_row, busy};
        default:  s_d.rdata = 32'h0000_0000;
      endcase
    end
    s_d.arready = !s_d.rvalid;

    // one bit stored per cycle, no acknowledge wait
    if (busy) begin
      if (s_q.sub == hw_subaddress_pins) begin
        s_d.ram[s_q.ptr][2'(wbase + s_q.lrow)] = bitv;
      end
      // a short last group still closes the column
      if ({1'b0, s_q.lrow} == per - 3'h1 || s_q.bcnt == 3'h7) begin
        s_d.lrow = 2'h0;
        if (s_q.ptr == LAST_COL) begin
          s_d.ptr = 6'h00;
          // overflow moves to the next cascaded device
          s_d.sub = s_q.sub + 3'h1;
        end else begin
          s_d.ptr = s_q.ptr + 6'h01;
        end
      end else begin
        s_d.lrow = s_q.lrow + 2'h1;
      end
      s_d.bcnt = s_q.bcnt + 3'h1;
      if (s_q.bcnt == 3'h7) begin
        s_d.ld = LD_IDLE;
      end
    end

    // fetch the next row while the current one shows
    if (s_q.scol < NUM_COLS) begin
      s_d.shreg = {s_q.ram[s_q.scol][2'(obase + nrow)], s_q.shreg[39:1]};
      s_d.scol = s_q.scol + 6'h01;
    end
    if (phase_end) begin
      s_d.disp = s_q.shreg;
      s_d.cur_row = row_idx;
      s_d.scol = 6'h00;
    end
    // Polarity flips each frame to keep the panel free of DC
    if (frame_start) begin
      s_d.pol = !s_q.pol;
    end

    s_d.ack = (s_q.sub == hw_subaddress_pins);

    for (int i = 0; i < 40; i++) begin
      s_d.seg[i] = !s_q.ctrl[CTRL_ENABLE] || (s_q.disp[i] ? s_q.pol : !s_q.pol);
    end
    for (int k = 0; k < 4; k++) begin
      s_d.bp[k] = !s_q.ctrl[CTRL_ENABLE] ||
                  ((bp_row(k, mux) == s_q.cur_row) ? !s_q.pol : s_q.pol);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
      s_q.seg <= '1;
      s_q.bp <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready     = s_q.awready;
  assign s_axi_wready      = s_q.wready;
  assign s_axi_bvalid      = s_q.bvalid;
  assign s_axi_bresp       = s_q.bresp;
  assign s_axi_arready     = s_q.arready;
  assign s_axi_rvalid      = s_q.rvalid;
  assign s_axi_rresp       = s_q.rresp;
  assign s_axi_rdata       = s_q.rdata;
  assign display_ack       = s_q.ack;
  assign segment_outputs   = s_q.seg;
  assign backplane_outputs = s_q.bp;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence byte_start;
    $rose(busy);
  endsequence
  sequence byte_body;
    busy [*8] ##1 !busy;
  endsequence

  chk_byte_bit_count: assert property (byte_start |-> byte_body)
    else $error("display byte not stored in eight cycles");

  chk_ptr_step_size: assert property (
    ($fell(busy) && $stable(s_q.ctrl)) |->
      {1'b0, s_q.ptr} == ((7'($past(s_q.ptr, 8)) + 7'(step_of(mux)) > 7'h27)
        ? 7'($past(s_q.ptr, 8)) + 7'(step_of(mux)) - 7'h28
        : 7'($past(s_q.ptr, 8)) + 7'(step_of(mux))))
    else $error("pointer step wrong for mode");

  chk_write_stall_busy: assert property (busy |=> !$rose(s_q.bvalid))
    else $error("write answered while a byte is still stored");

  chk_store_gate_sub: assert property (
    (busy && s_q.sub != hw_subaddress_pins) |=> $stable(s_q.ram))
    else $error("RAM written on subaddress mismatch");

  chk_wrap_sub_inc: assert property (
    (busy && s_q.ptr == LAST_COL) ##1 (s_q.ptr == 6'h00) |->
      s_q.sub == $past(s_q.sub) + 3'h1)
    else $error("subaddress not advanced on pointer wrap");

  chk_disp_load_row: assert property (phase_end |=>
    s_q.disp == $past(s_q.shreg) && s_q.scol == 6'h00)
    else $error("display register not loaded at phase end");

  chk_bp_pair_1_3: assert property ((mux == MUX_1_3) [*2] |->
    s_q.bp[3] == s_q.bp[1])
    else $error("backplane 3 differs from backplane 1");

  chk_bp_pair_1_2: assert property ((mux == MUX_1_2) [*2] |->
    s_q.bp[0] == s_q.bp[2] && s_q.bp[1] == s_q.bp[3])
    else $error("paired backplanes differ");

  chk_bp_all_static: assert property ((mux == MUX_STATIC) [*2] |->
    s_q.bp == {4{s_q.bp[0]}})
    else $error("static backplanes differ");

  chk_ext_tick_hold: assert property (
    (s_q.ctrl[CTRL_EXT_CLK] && !ext_rise && sync_n_in) |=> $stable(row_idx))
    else $error("row moved without external clock edge");

  chk_ack_from_match: assert property (1'b1 |=>
    s_q.ack == $past(s_q.sub == hw_subaddress_pins))
    else $error("acknowledge does not follow subaddress match");

  chk_store_row_bit: assert property (
    (busy && s_q.sub == hw_subaddress_pins) |=>
      s_q.ram[$past(s_q.ptr)][$past(2'(wbase + s_q.lrow))] == $past(bitv))
    else $error("display bit not stored at pointer and row");

  chk_ptr_in_range: assert property (s_q.ptr <= LAST_COL)
    else $error("data pointer outside the RAM");

  chk_blank_disabled: assert property (!s_q.ctrl[CTRL_ENABLE] |=>
    s_q.seg == '1 && s_q.bp == '1)
    else $error("outputs driven while display disabled");

  chk_sync_one_cycle: assert property (sync_n_oe |=> !sync_n_oe)
    else $error("own sync pulse longer than one cycle");
endmodule // lcd_ram_load_and_scan

/* lcd_pkg.sv */
// Shared constants, types and decode helpers of the LCD RAM load/scan core.
// Assumes one 40 MHz clock and an AXI4-Lite master for the registers.
// Behaviour
// - Frame rate is the clock divided by 2880 normally, 480 in power saving.
// - Internal clock uses the mode setting; external clock follows its pin.
// - A display byte arriving while one is still being stored is held off.
// - Active-low cascade sync keeps multiplex timing aligned between drivers.
// - Next RAM row shifts into a shift register while current row shows.
// - Forty segment outputs combine display register bits with backplane timing.
// - In 1:3 mode backplane 3 copies backplane 1.
// - In 1:2 mode backplanes 0/2 and 1/3 carry identical waveforms.
// - In static mode all four backplanes carry one waveform.
// - Column n drives segment n, row k backplane k; 1 means on.
// - Display bits are written into RAM as they arrive, no acknowledge wait.
// - Static mode writes eight bits into row 0 of eight columns.
// - 1:2 mode writes bit pairs into rows 0 and 1 of four columns.
// - 1:3 mode writes triples into three columns, third column row 2 untouched.
// - 1:4 mode writes four-bit groups into rows 0 to 3 of two columns.
// - Pointer advances 8, 4, 3 or 2 per byte; load command sets it.
// - Data stored only on subaddress match; pointer advances regardless.
// - Device select sets subaddress counter; pointer overflow increments it.
// - Output bank scans rows 0-3, 0-2, 0-1 or 0 per mode.
// - Output bank select shows row 2, or rows 2 and 3, instead.
// - Input bank select writes row 2, or rows 2 and 3; independent.
// - Reset gives 1:4 mode, third bias, banks, pointer and counter cleared.
// - Every byte written to the data register is display data.
// - Only the device whose subaddress matches acknowledges display bytes.
package lcd_pkg;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PTR  = 8'h04;
  localparam logic [7:0] REG_SUB  = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;

  // Control register fields and reset value (1:4 mode, third bias)
  localparam int unsigned CTRL_MUX_LSB  = 0;
  localparam int unsigned CTRL_PSAVE    = 2;
  localparam int unsigned CTRL_EXT_CLK  = 3;
  localparam int unsigned CTRL_IN_BANK  = 4;
  localparam int unsigned CTRL_OUT_BANK = 5;
  localparam int unsigned CTRL_ENABLE   = 6;
  localparam int unsigned CTRL_BIAS_HALF = 7;
  localparam logic [7:0]  CTRL_RESET    = 8'h03;

  // Frame division ratios: 2880 and 480
  localparam logic [11:0] FRAME_DIV_NORMAL = 12'hB40;
  localparam logic [11:0] FRAME_DIV_SAVE   = 12'h1E0;

  localparam logic [5:0] LAST_COL     = 6'h27;
  localparam logic [5:0] NUM_COLS     = 6'h28;
  localparam logic [1:0] BANK_ALT_ROW = 2'h2;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    MUX_STATIC = 2'b00,
    MUX_1_2    = 2'b01,
    MUX_1_3    = 2'b10,
    MUX_1_4    = 2'b11
  } lcd_mux_t;

  typedef enum logic {
    LD_IDLE = 1'b0,
    LD_BITS = 1'b1
  } lcd_ld_t;

  // Rows scanned per frame in each mode
  function automatic logic [2:0] rows_of(input lcd_mux_t m);
    case (m)
      MUX_STATIC: rows_of = 3'h1;
      MUX_1_2:    rows_of = 3'h2;
      MUX_1_3:    rows_of = 3'h3;
      default:    rows_of = 3'h4;
    endcase
  endfunction

  // Pointer step per display byte
  function automatic logic [5:0] step_of(input lcd_mux_t m);
    case (m)
      MUX_STATIC: step_of = 6'h08;
      MUX_1_2:    step_of = 6'h04;
      MUX_1_3:    step_of = 6'h03;
      default:    step_of = 6'h02;
    endcase
  endfunction

  // RAM row shown on backplane k
  function automatic logic [1:0] bp_row(input int k, input lcd_mux_t m);
    case (m)
      MUX_STATIC: bp_row = 2'h0;
      MUX_1_2:    bp_row = 2'(k % 2);
      MUX_1_3:    bp_row = (k == 3) ? 2'h1 : 2'(k);
      default:    bp_row = 2'(k);
    endcase
  endfunction

endpackage

/* lcd_edge_det.sv */
// Rising-edge detector for the external clock pin.
// Assumes the pin is already synchronous to clk_sys.
`timescale 1ns/1ps
module lcd_edge_det import lcd_pkg::*; (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic level_in,
  output logic      rise
);
  typedef struct packed {
    logic prev;
  } lcd_edge_t;
  lcd_edge_t s_q;
  lcd_edge_t s_d;

  // Remember last level
  always_comb begin
    s_d.prev = level_in;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise = level_in && !s_q.prev;
endmodule // lcd_edge_det

/* lcd_frame_timer.sv */
// Frame and row-phase timer with cascade sync.
// Assumes tick marks each LCD clock period and sync_n_in is the wired line.
`timescale 1ns/1ps
module lcd_frame_timer import lcd_pkg::*; #(
  parameter logic [11:0] DIV_NORMAL = FRAME_DIV_NORMAL,
  parameter logic [11:0] DIV_SAVE   = FRAME_DIV_SAVE
) (
  input  wire logic  clk_sys,
  input  wire logic  reset,
  input  wire logic  tick,
  input  wire logic  power_save,
  input  lcd_mux_t   mux,
  input  wire logic  sync_n_in,
  output logic       sync_n_out,
  output logic       sync_n_oe,
  output logic [1:0] row_idx,
  output logic       phase_end,
  output logic       frame_start
);
  typedef struct packed {
    logic [11:0] pcnt;
    logic [1:0]  row;
    logic        pe;
    logic        fs;
    logic        drv;
  } lcd_tmr_t;
  lcd_tmr_t    s_q;
  lcd_tmr_t    s_d;
  logic [11:0] len;
  logic [2:0]  last_row;
  logic        resync;
  logic [11:0] ftk_q;
  logic        clean_q;
  logic [2:0]  cfg_q;

  // Ticks per row phase; the divisions fold to constants
  function automatic logic [11:0] phase_len(input logic ps, input lcd_mux_t m);
    case (m)
      MUX_STATIC: phase_len = ps ? DIV_SAVE : DIV_NORMAL;
      MUX_1_2:    phase_len = ps ? 12'(DIV_SAVE / 2) : 12'(DIV_NORMAL / 2);
      MUX_1_3:    phase_len = ps ? 12'(DIV_SAVE / 3) : 12'(DIV_NORMAL / 3);
      default:    phase_len = ps ? 12'(DIV_SAVE / 4) : 12'(DIV_NORMAL / 4);
    endcase
  endfunction

  always_comb begin
    len = phase_len(power_save, mux);
    last_row = rows_of(mux) - 3'h1;
    resync = !sync_n_in && !s_q.drv && (s_q.row != 2'h0 || s_q.pcnt > 12'h001);
    s_d = s_q;
    s_d.pe = 1'b0;
    s_d.fs = 1'b0;
    s_d.drv = 1'b0;
    if (resync) begin
      s_d.pcnt = 12'h000;
      s_d.row = 2'h0;
      s_d.pe = 1'b1;
    end else if (tick) begin
      if (s_q.pcnt >= len - 12'h001) begin
        s_d.pcnt = 12'h000;
        s_d.pe = 1'b1;
        if ({1'b0, s_q.row} >= last_row) begin
          s_d.row = 2'h0;
          s_d.fs = 1'b1;
          s_d.drv = 1'b1;
        end else begin
          s_d.row = s_q.row + 2'h1;
        end
      end else begin
        s_d.pcnt = s_q.pcnt + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Open drain: only ever pulls low
  assign sync_n_out  = !s_q.drv;
  assign sync_n_oe   = s_q.drv;
  assign row_idx     = s_q.row;
  assign phase_end   = s_q.pe;
  assign frame_start = s_q.fs;

  // Ticks since last frame start, for checking only
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ftk_q <= 12'h000;
      clean_q <= 1'b0;
      cfg_q <= 3'h0;
    end else begin
      ftk_q <= s_d.fs ? 12'h000 : ftk_q + {11'h000, tick};
      cfg_q <= {power_save, mux};
      if (s_d.fs) begin
        clean_q <= 1'b1;
      end else if (resync || cfg_q != {power_save, mux}) begin
        clean_q <= 1'b0;
      end
    end
  end

  chk_frame_div_len: assert property (@(posedge clk_sys) disable iff (reset)
    (s_d.fs && clean_q && cfg_q == {power_save, mux}) |->
      ftk_q == (power_save ? DIV_SAVE : DIV_NORMAL) - 12'h001)
    else $error("frame length differs from division ratio");
endmodule // lcd_frame_timer

/* lcd_cascade_peer.sv */
// Model of a second cascaded driver on the shared sync line.
// Assumes the line is pulled up; go pulses one clock per foreign frame.
`timescale 1ns/1ps
module lcd_cascade_peer (
  input  wire logic clk_sys,
  input  wire logic go,
  input  wire logic dut_out,
  input  wire logic dut_oe,
  output logic      line_n
);
  logic pull_q;

  always_ff @(posedge clk_sys) begin
    pull_q <= go;
  end

  // Pull-up wins unless someone drives low
  assign line_n = ~(pull_q | (dut_oe & ~dut_out));
endmodule // lcd_cascade_peer

/* lcd_ram_load_and_scan_tb.sv */
// Self-checking bench: AXI4-Lite tasks, display, frame and sync checks.
// Assumes the frame timer runs with its full default division ratios.
`timescale 1ns/1ps
module lcd_ram_load_and_scan_tb import lcd_pkg::*; ;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic        ext_clk_pin = 1'b0;
  logic [2:0]  hw = 3'h0;
  logic        peer_go = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        sync_line, sync_n_out, sync_n_oe, display_ack;
  logic [39:0] seg;
  logic [3:0]  bp;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;

  lcd_ram_load_and_scan dut_u (
    .clk_sys(clk_sys), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_clk_pin(ext_clk_pin), .hw_subaddress_pins(hw),
    .sync_n_in(sync_line), .sync_n_out(sync_n_out), .sync_n_oe(sync_n_oe),
    .display_ack(display_ack), .segment_outputs(seg),
    .backplane_outputs(bp)
  );

  lcd_cascade_peer peer_u (
    .clk_sys(clk_sys), .go(peer_go), .dut_out(sync_n_out),
    .dut_oe(sync_n_oe), .line_n(sync_line)
  );

  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  // External LCD clock, one rise every two cycles; ignored until selected
  always @(posedge clk_sys) begin
    ext_clk_pin <= ~ext_clk_pin;
  end

  // Hang guard; ceiling well above the planned run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic results();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] seen,
                     input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output int lat,
                    output logic [1:0] rsp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    lat = 0;
    awaddr <= a;
    wdata <= 32'(d);
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      lat++;
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok && bvalid === 1'b1));
    rsp = bresp;
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    int l;
    logic [1:0] r;
    wr(a, d, l, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] rsp);
    logic a_ok;
    a_ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (!a_ok && arready === 1'b1) begin
        a_ok = 1'b1;
        arvalid <= 1'b0;
      end
    end while (!(a_ok && rvalid === 1'b1));
    d = rdata;
    rsp = rresp;
  endtask

  // A display byte is still loading for eight cycles after its write
  task automatic settle();
    logic [31:0] d;
    logic [1:0] r;
    do rd(REG_STAT, d, r); while (d[0] !== 1'b0);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    settle();
    rd(a, d, r);
    chk($sformatf("reg %h", a), 40'(d), 40'(exp));
  endtask

  task automatic wait_sync();
    do @(posedge clk_sys); while (sync_n_oe !== 1'b1);
  endtask

  // Cycles from one own sync pulse to the next
  task automatic meas(output int n);
    wait_sync();
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (sync_n_oe !== 1'b1);
  endtask

  // Two frames: the first may show a row fetched before the write
  task automatic frame();
    repeat (2) wait_sync();
    repeat (3) @(posedge clk_sys);
  endtask

  // Backplane groups that must match in mode m, sampled over a frame
  task automatic pair(input int m);
    int bad;
    bad = 0;
    repeat (80) begin
      repeat (37) @(posedge clk_sys);
      if (m == 0) bad += int'(bp !== {4{bp[0]}});
      else if (m == 1) bad += int'(bp[0] !== bp[2] || bp[1] !== bp[3]);
      else bad += int'(bp[3] !== bp[1]);
    end
    chk("backplane pairing", 40'(bad), 40'h00_0000_0000);
  endtask

  // Main sequence
  initial begin
    int l1, l2, n;
    logic [1:0] r;
    logic [31:0] d;
    int st[4];
    st = '{8, 4, 3, 2};
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk("seg idle", seg, 40'hFF_FFFF_FFFF);
    chk("bp idle", 40'(bp), 40'h00_0000_000F);
    rchk(REG_CTRL, 32'h0000_0003);
    rchk(REG_PTR, 32'h0000_0000);
    rchk(REG_SUB, 32'h0000_0000);
    rd(8'h14, d, r);
    chk("unmapped rresp", 40'(r), 40'(RESP_SLVERR));
    chk("unmapped rdata", 40'(d), 40'h00_0000_0000);
    wr(8'h18, 8'h00, l1, r);
    chk("unmapped bresp", 40'(r), 40'(RESP_SLVERR));
    // Static mode: two bytes back to back, MSB to lowest column
    w(REG_CTRL, 8'h40);
    w(REG_PTR, 8'h00);
    wr(REG_DATA, 8'hC1, l1, r);
    wr(REG_DATA, 8'h0F, l2, r);
    chk("stall", 40'(l2 > l1), 40'h00_0000_0001);
    rchk(REG_PTR, 32'h0000_0010);
    frame();
    chk("seg", 40'(seg[15:0] ^ {16{bp[0]}}), 40'h00_0000_F083);
    pair(0);
    // Input bank to row 2, shown only once output bank moves
    w(REG_CTRL, 8'h50);
    w(REG_PTR, 8'h00);
    w(REG_DATA, 8'hFF);
    w(REG_CTRL, 8'h40);
    frame();
    chk("seg bank0", 40'(seg[15:0] ^ {16{bp[0]}}), 40'h00_0000_F083);
    w(REG_CTRL, 8'h60);
    frame();
    chk("seg bank1", 40'(seg[15:0] ^ {16{bp[0]}}), 40'h00_0000_00FF);
    // Pointer step in every mode
    for (int m = 0; m < 4; m++) begin
      w(REG_CTRL, 8'(8'h40 | m));
      w(REG_PTR, 8'h00);
      w(REG_DATA, 8'h00);
      rchk(REG_PTR, 32'(st[m]));
    end
    // Wrap past the last column moves on to the next subaddress
    w(REG_PTR, 8'h27);
    w(REG_DATA, 8'h00);
    rchk(REG_PTR, 32'h0000_0001);
    rchk(REG_SUB, 32'h0000_0001);
    chk("ack off", 40'(display_ack), 40'h00_0000_0000);
    w(REG_DATA, 8'hFF);
    rchk(REG_PTR, 32'h0000_0003);
    hw <= 3'h1;
    repeat (3) @(posedge clk_sys);
    chk("ack on", 40'(display_ack), 40'h00_0000_0001);
    hw <= 3'h0;
    w(REG_SUB, 8'h00);
    w(REG_CTRL, 8'h41);
    pair(1);
    w(REG_CTRL, 8'h42);
    pair(2);
    // Frame periods: normal, power save, external clock
    w(REG_CTRL, 8'h43);
    meas(n);
    chk("frame normal", 40'(n), 40'd2880);
    w(REG_CTRL, 8'h47);
    meas(n);
    chk("frame save", 40'(n), 40'd480);
    w(REG_CTRL, 8'h4F);
    meas(n);
    chk("frame ext", 40'(n), 40'd960);
    // A foreign frame start realigns the next own pulse
    w(REG_CTRL, 8'h43);
    wait_sync();
    repeat (1000) @(posedge clk_sys);
    peer_go <= 1'b1;
    @(posedge clk_sys);
    peer_go <= 1'b0;
    // Line low one cycle later, timer restarts one edge after that
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (sync_n_oe !== 1'b1);
    chk("resync", 40'(n), 40'd2882);
    results();
  end
endmodule // lcd_ram_load_and_scan_tb
